// ==== src/dag_pkg.sv ====
// Purpose: constants for the data address generator
// Assumes: 16-bit data path, byte addressed data space
// Notes: register offsets are byte addresses on the bus
package dag_pkg;
  localparam logic [6:0] OFF_CORE_CONTROL = 7'h44;
  localparam logic [6:0] OFF_CIRC_CONTROL = 7'h46;
  localparam logic [6:0] OFF_X_START = 7'h48;
  localparam logic [6:0] OFF_X_END = 7'h4a;
  localparam logic [6:0] OFF_Y_START = 7'h4c;
  localparam logic [6:0] OFF_Y_END = 7'h4e;
  localparam logic [6:0] OFF_BITREV = 7'h50;
  localparam logic [6:0] OFF_DISI_COUNT = 7'h52;
  localparam logic [15:0] RST_CORE_CONTROL = 16'h0020;
  localparam logic [15:0] RST_CIRC_CONTROL = 16'h0000;
  localparam logic [15:0] RST_X_START = 16'h0000;
  localparam logic [15:0] RST_X_END = 16'h0001;
  localparam logic [15:0] RST_Y_START = 16'h0000;
  localparam logic [15:0] RST_Y_END = 16'h0001;
  localparam logic [15:0] RST_BITREV = 16'h0000;
  localparam logic [15:0] RST_DISI_COUNT = 16'h0000;
  localparam logic [15:0] MASK_CORE_CONTROL = 16'h1fff;
  localparam logic [15:0] MASK_CIRC_CONTROL = 16'hcfff;
  localparam logic [15:0] MASK_DISI_COUNT = 16'h3fff;
  localparam int POS_X_CIRC_EN = 15;
  localparam int POS_Y_CIRC_EN = 14;
  localparam int POS_BITREV_SEL = 8;
  localparam int POS_Y_SEL = 4;
  localparam int POS_X_SEL = 0;
  localparam int POS_BITREV_EN = 15;
  localparam logic [3:0] SEL_NONE = 4'hf;
  localparam logic [15:0] NEAR_LIMIT = 16'h2000;
  localparam logic [15:0] NEAR_MASK = 16'h1fff;
  typedef enum logic [7:0] {
    DAG_FILE_DIRECT = 8'h01,
    DAG_REG_DIRECT = 8'h02,
    DAG_INDIRECT = 8'h04,
    DAG_POST_MOD = 8'h08,
    DAG_PRE_MOD = 8'h10,
    DAG_REG_OFFSET = 8'h20,
    DAG_LIT_OFFSET = 8'h40,
    DAG_LITERAL = 8'h80
  } dag_mode_e;
  typedef enum logic [2:0] {
    DAG_BUS_IDLE = 3'h1,
    DAG_BUS_READ = 3'h2,
    DAG_BUS_ACK = 3'h4
  } dag_bus_e;
endpackage : dag_pkg

// ==== src/dag_unit.sv ====
// Purpose: one address unit, combinational effective address
// Assumes: mode one-hot from the decoder
// Notes: circular correction done by wrapping past start or end
`timescale 1ns/1ps
`default_nettype none
module dag_unit (
  input wire logic [7:0] mode_i,
  input wire logic [15:0] base_i,
  input wire logic [15:0] offset_i,
  input wire logic [15:0] literal_i,
  input wire logic [15:0] step_i,
  input wire logic circ_on_i,
  input wire logic bitrev_on_i,
  input wire logic [15:0] bitrev_mod_i,
  input wire logic [15:0] buf_start_i,
  input wire logic [15:0] buf_end_i,
  input wire logic near_only_i,
  output logic [15:0] ea_o,
  output logic [15:0] wb_val_o,
  output logic wb_en_o
);
  logic [15:0] raw_ea;
  logic [15:0] moved;
  logic [15:0] len;
  logic [15:0] fixed;
  logic [15:0] rev;

  function automatic logic [15:0] wrap(input logic [15:0] a, input logic [15:0] s,
                                       input logic [15:0] e, input logic [15:0] l);
    // beyond, not equal: jumps past a bound still wrap
    if (a > e) begin
      wrap = 16'(a - l);
    end else if (a < s) begin
      wrap = 16'(a + l);
    end else begin
      wrap = a;
    end
  endfunction : wrap

  function automatic logic [15:0] flip(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      flip[i] = v[15 - i];
    end
  endfunction : flip

  always_comb begin
    len = 16'(buf_end_i - buf_start_i + 16'h0001);
    // bit-reversed carry on the modifier
    rev = flip(16'(flip(base_i) + flip(bitrev_mod_i)));
    moved = 16'(base_i + step_i);
    raw_ea = base_i;
    unique case (1'b1)
      mode_i[0]: raw_ea = near_only_i ? (literal_i & dag_pkg::NEAR_MASK) : literal_i;
      mode_i[1]: raw_ea = base_i;
      mode_i[2]: raw_ea = base_i;
      mode_i[3]: raw_ea = base_i;
      mode_i[4]: raw_ea = moved;
      mode_i[5]: raw_ea = 16'(base_i + offset_i);
      mode_i[6]: raw_ea = 16'(base_i + literal_i);
      mode_i[7]: raw_ea = literal_i;
      default: raw_ea = base_i;
    endcase
    fixed = moved;
    if (bitrev_on_i && (mode_i[3] || mode_i[4])) begin
      fixed = rev;
    end else if (circ_on_i) begin
      fixed = wrap(moved, buf_start_i, buf_end_i, len);
    end
    ea_o = raw_ea;
    if (mode_i[4]) begin
      ea_o = fixed;
    end else if (circ_on_i && (mode_i[5] || mode_i[6])) begin
      ea_o = wrap(raw_ea, buf_start_i, buf_end_i, len);
    end
    wb_en_o = mode_i[3] | mode_i[4];
    wb_val_o = fixed;
  end
endmodule : dag_unit
`default_nettype wire

// ==== src/dag_top.sv ====
// Purpose: dual address generator with its control registers
// Assumes: decoder holds inputs steady one cycle per request
// Notes: results registered, one cycle after req_i
//
// Behaviour
// - two independent units, X and Y, compute addresses in the same cycle.
// - Y unit serves only word reads of dual-operand MAC instructions.
// - linear and circular on data and program space; bit-reverse data only.
// - file-register direct address is 13 bits, near 8192 bytes only.
// - file-register instructions imply working register zero as destination option.
// - move instruction reaches the whole data space.
// - file direct takes address from instruction; register direct uses register value.
// - plain indirect address equals the base pointer, pointer unchanged.
// - post-modify uses old pointer then writes back pointer plus step.
// - pre-modify adds signed step first and uses the result.
// - register offset address is base plus offset pointer.
// - literal offset address is base plus instruction literal.
// - three-operand first source is always a working register direct.
// - second source is register, memory or 5-bit literal; result reg or memory.
// - general modes include direct, indirect, pre, post and 5/10-bit literals.
// - X circular only when enabled and X select not 15; Y likewise.
// - bit-reverse only with select not 15, enable set, pre/post increment.
// - corrected address written back only in pre/post; offset forms not.
// - boundary checks use beyond, not equal, so jumps still wrap.
`timescale 1ns/1ps
`default_nettype none
module dag_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [1:0] avs_byteenable_i,
  input wire logic [15:0] avs_writedata_i,
  output logic [15:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic req_i,
  input wire logic mac_word_read_i,
  input wire logic file_reg_i,
  input wire logic move_i,
  input wire logic three_op_i,
  input wire logic [1:0] src2_kind_i,
  input wire logic [9:0] short_literal_i,
  input wire logic lit10_i,
  input wire logic [7:0] x_mode_i,
  input wire logic [3:0] x_base_sel_i,
  input wire logic [15:0] x_base_i,
  input wire logic [15:0] x_offset_i,
  input wire logic [15:0] x_literal_i,
  input wire logic [15:0] x_step_i,
  input wire logic x_program_space_i,
  input wire logic [7:0] y_mode_i,
  input wire logic [3:0] y_base_sel_i,
  input wire logic [15:0] y_base_i,
  input wire logic [15:0] y_offset_i,
  input wire logic [15:0] y_step_i,
  output logic [15:0] x_ea_o,
  output logic [15:0] x_wb_val_o,
  output logic x_wb_en_o,
  output logic x_program_space_o,
  output logic [15:0] y_ea_o,
  output logic [15:0] y_wb_val_o,
  output logic y_wb_en_o,
  output logic y_valid_o,
  output logic [3:0] dest_reg_o,
  output logic [15:0] src1_reg_o,
  output logic [15:0] src2_literal_o,
  output logic src2_is_memory_o,
  output logic ea_valid_o,
  output logic [15:0] core_control_o,
  output logic [13:0] disi_count_o
);
  //----------------------------------------
  // registers
  //----------------------------------------
  logic [15:0] core_control, next_core_control;
  logic [15:0] circ_control, next_circ_control;
  logic [15:0] x_start, next_x_start;
  logic [15:0] x_end, next_x_end;
  logic [15:0] y_start, next_y_start;
  logic [15:0] y_end, next_y_end;
  logic [15:0] bitrev_control, next_bitrev_control;
  logic [15:0] disi_count, next_disi_count;
  dag_pkg::dag_bus_e bus_state, next_bus_state;
  logic [15:0] readdata, next_readdata;
  logic [15:0] wmask;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m, input logic [15:0] keep);
    merge = (old & ~m) | (nw & m & keep);
  endfunction : merge

  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction : hit

  always_comb begin
    wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    next_core_control = core_control;
    next_circ_control = circ_control;
    next_x_start = x_start;
    next_x_end = x_end;
    next_y_start = y_start;
    next_y_end = y_end;
    next_bitrev_control = bitrev_control;
    next_disi_count = disi_count;
    next_bus_state = bus_state;
    next_readdata = readdata;
    // decrements once per cycle while nonzero
    if (disi_count != 16'h0000) begin
      next_disi_count = 16'(disi_count - 16'h0001);
    end
    unique case (bus_state)
      dag_pkg::DAG_BUS_IDLE: begin
        if (avs_write_i) begin
          next_bus_state = dag_pkg::DAG_BUS_ACK;
          if (hit(avs_address_i, dag_pkg::OFF_CORE_CONTROL)) begin
            next_core_control = merge(core_control, avs_writedata_i, wmask, dag_pkg::MASK_CORE_CONTROL);
          end
          if (hit(avs_address_i, dag_pkg::OFF_CIRC_CONTROL)) begin
            next_circ_control = merge(circ_control, avs_writedata_i, wmask, dag_pkg::MASK_CIRC_CONTROL);
          end
          if (hit(avs_address_i, dag_pkg::OFF_X_START)) begin
            next_x_start = merge(x_start, avs_writedata_i, wmask, 16'hfffe);
          end
          if (hit(avs_address_i, dag_pkg::OFF_X_END)) begin
            next_x_end = merge(x_end, avs_writedata_i, wmask, 16'hfffe) | 16'h0001;
          end
          if (hit(avs_address_i, dag_pkg::OFF_Y_START)) begin
            next_y_start = merge(y_start, avs_writedata_i, wmask, 16'hfffe);
          end
          if (hit(avs_address_i, dag_pkg::OFF_Y_END)) begin
            next_y_end = merge(y_end, avs_writedata_i, wmask, 16'hfffe) | 16'h0001;
          end
          if (hit(avs_address_i, dag_pkg::OFF_BITREV)) begin
            next_bitrev_control = merge(bitrev_control, avs_writedata_i, wmask, 16'hffff);
          end
          if (hit(avs_address_i, dag_pkg::OFF_DISI_COUNT)) begin
            next_disi_count = merge(disi_count, avs_writedata_i, wmask, dag_pkg::MASK_DISI_COUNT);
          end
        end else if (avs_read_i) begin
          next_bus_state = dag_pkg::DAG_BUS_READ;
        end
      end
      dag_pkg::DAG_BUS_READ: begin
        next_bus_state = dag_pkg::DAG_BUS_ACK;
        next_readdata = 16'h0000;
        if (hit(avs_address_i, dag_pkg::OFF_CORE_CONTROL)) begin
          next_readdata = core_control;
        end
        if (hit(avs_address_i, dag_pkg::OFF_CIRC_CONTROL)) begin
          next_readdata = circ_control;
        end
        if (hit(avs_address_i, dag_pkg::OFF_X_START)) begin
          next_readdata = x_start;
        end
        if (hit(avs_address_i, dag_pkg::OFF_X_END)) begin
          next_readdata = x_end;
        end
        if (hit(avs_address_i, dag_pkg::OFF_Y_START)) begin
          next_readdata = y_start;
        end
        if (hit(avs_address_i, dag_pkg::OFF_Y_END)) begin
          next_readdata = y_end;
        end
        if (hit(avs_address_i, dag_pkg::OFF_BITREV)) begin
          next_readdata = bitrev_control;
        end
        if (hit(avs_address_i, dag_pkg::OFF_DISI_COUNT)) begin
          next_readdata = disi_count;
        end
      end
      dag_pkg::DAG_BUS_ACK: begin
        next_bus_state = dag_pkg::DAG_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      core_control <= dag_pkg::RST_CORE_CONTROL;
      circ_control <= dag_pkg::RST_CIRC_CONTROL;
      x_start <= dag_pkg::RST_X_START;
      x_end <= dag_pkg::RST_X_END;
      y_start <= dag_pkg::RST_Y_START;
      y_end <= dag_pkg::RST_Y_END;
      bitrev_control <= dag_pkg::RST_BITREV;
      disi_count <= dag_pkg::RST_DISI_COUNT;
      bus_state <= dag_pkg::DAG_BUS_IDLE;
      readdata <= 16'h0000;
    end else begin
      core_control <= next_core_control;
      circ_control <= next_circ_control;
      x_start <= next_x_start;
      x_end <= next_x_end;
      y_start <= next_y_start;
      y_end <= next_y_end;
      bitrev_control <= next_bitrev_control;
      disi_count <= next_disi_count;
      bus_state <= next_bus_state;
      readdata <= next_readdata;
    end
  end

  //----------------------------------------
  // address units
  //----------------------------------------
  logic x_circ_on, y_circ_on, bitrev_on;
  logic [7:0] y_mode_eff;
  logic [15:0] x_ea, x_wb_val, y_ea, y_wb_val;
  logic x_wb_en, y_wb_en;

  always_comb begin
    x_circ_on = circ_control[dag_pkg::POS_X_CIRC_EN] &&
                (circ_control[dag_pkg::POS_X_SEL +: 4] != dag_pkg::SEL_NONE) &&
                (x_base_sel_i == circ_control[dag_pkg::POS_X_SEL +: 4]);
    y_circ_on = circ_control[dag_pkg::POS_Y_CIRC_EN] &&
                (circ_control[dag_pkg::POS_Y_SEL +: 4] != dag_pkg::SEL_NONE) &&
                (y_base_sel_i == circ_control[dag_pkg::POS_Y_SEL +: 4]);
    bitrev_on = bitrev_control[dag_pkg::POS_BITREV_EN] && !x_program_space_i &&
                (circ_control[dag_pkg::POS_BITREV_SEL +: 4] != dag_pkg::SEL_NONE) &&
                (x_base_sel_i == circ_control[dag_pkg::POS_BITREV_SEL +: 4]) &&
                !x_step_i[15];
    y_mode_eff = mac_word_read_i ? y_mode_i : 8'h00;
  end

  dag_unit u_x_unit (
    .mode_i(x_mode_i),
    .base_i(x_base_i),
    .offset_i(x_offset_i),
    .literal_i(x_literal_i),
    .step_i(x_step_i),
    .circ_on_i(x_circ_on),
    .bitrev_on_i(bitrev_on),
    .bitrev_mod_i({1'b0, bitrev_control[14:0]}),
    .buf_start_i(x_start),
    .buf_end_i(x_end),
    .near_only_i(file_reg_i && !move_i),
    .ea_o(x_ea),
    .wb_val_o(x_wb_val),
    .wb_en_o(x_wb_en)
  );

  dag_unit u_y_unit (
    .mode_i(y_mode_eff),
    .base_i(y_base_i),
    .offset_i(y_offset_i),
    .literal_i(16'h0000),
    .step_i(y_step_i),
    .circ_on_i(y_circ_on),
    .bitrev_on_i(1'b0),
    .bitrev_mod_i(16'h0000),
    .buf_start_i(y_start),
    .buf_end_i(y_end),
    .near_only_i(1'b0),
    .ea_o(y_ea),
    .wb_val_o(y_wb_val),
    .wb_en_o(y_wb_en)
  );

  //----------------------------------------
  // registered results
  //----------------------------------------
  logic [15:0] next_x_ea, next_y_ea, next_src2;
  logic next_x_wb, next_y_wb, next_y_valid;
  logic [3:0] next_dest;

  always_comb begin
    next_x_ea = x_ea;
    next_y_ea = mac_word_read_i ? {y_ea[15:1], 1'b0} : 16'h0000;
    next_x_wb = req_i & x_wb_en;
    next_y_wb = req_i & y_wb_en & mac_word_read_i;
    next_y_valid = req_i & mac_word_read_i;
    next_dest = file_reg_i ? 4'h0 : x_base_sel_i;
    next_src2 = lit10_i ? {6'h00, short_literal_i} : {11'h000, short_literal_i[4:0]};
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      x_ea_o <= 16'h0000;
      x_wb_val_o <= 16'h0000;
      x_wb_en_o <= 1'b0;
      x_program_space_o <= 1'b0;
      y_ea_o <= 16'h0000;
      y_wb_val_o <= 16'h0000;
      y_wb_en_o <= 1'b0;
      y_valid_o <= 1'b0;
      dest_reg_o <= 4'h0;
      src1_reg_o <= 16'h0000;
      src2_literal_o <= 16'h0000;
      src2_is_memory_o <= 1'b0;
      ea_valid_o <= 1'b0;
      core_control_o <= dag_pkg::RST_CORE_CONTROL;
      disi_count_o <= 14'h0000;
      avs_readdata_o <= 16'h0000;
      avs_waitrequest_o <= 1'b1;
    end else begin
      x_ea_o <= next_x_ea;
      x_wb_val_o <= x_wb_val;
      x_wb_en_o <= next_x_wb;
      x_program_space_o <= x_program_space_i;
      y_ea_o <= next_y_ea;
      y_wb_val_o <= mac_word_read_i ? y_wb_val : 16'h0000;
      y_wb_en_o <= next_y_wb;
      y_valid_o <= next_y_valid;
      dest_reg_o <= next_dest;
      src1_reg_o <= three_op_i ? x_offset_i : 16'h0000;
      src2_literal_o <= next_src2;
      src2_is_memory_o <= three_op_i && (src2_kind_i == 2'h1);
      ea_valid_o <= req_i;
      core_control_o <= next_core_control;
      disi_count_o <= next_disi_count[13:0];
      avs_readdata_o <= next_readdata;
      avs_waitrequest_o <= (next_bus_state != dag_pkg::DAG_BUS_ACK);
    end
  end
endmodule : dag_top
`default_nettype wire

// ==== tb/dag_monitor.sv ====
// Purpose: port checker for the address generator
// Assumes: one-hot modes, results one edge after req_i
// Notes: bound to dag_top below
`timescale 1ns/1ps
`default_nettype none
module dag_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic mac_word_read_i,
  input wire logic file_reg_i,
  input wire logic move_i,
  input wire logic three_op_i,
  input wire logic [7:0] x_mode_i,
  input wire logic [15:0] x_base_i,
  input wire logic [15:0] x_offset_i,
  input wire logic x_program_space_i,
  input wire logic [15:0] x_ea_o,
  input wire logic [15:0] x_wb_val_o,
  input wire logic x_wb_en_o,
  input wire logic x_program_space_o,
  input wire logic [15:0] y_ea_o,
  input wire logic y_valid_o,
  input wire logic [3:0] dest_reg_o,
  input wire logic [15:0] src1_reg_o,
  input wire logic ea_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // address path relations
  // ----------------------------------------
  a_valid_next: assert property (req_i |=> ea_valid_o)
    else $error("no result after request");
  a_y_refuse: assert property (req_i && !mac_word_read_i |=> !y_valid_o && y_ea_o == 16'h0)
    else $error("y unit active outside mac read");
  a_space_pass: assert property (req_i |=> x_program_space_o == $past(x_program_space_i))
    else $error("space flag lost");
  a_near_only: assert property (req_i && file_reg_i && !move_i && x_mode_i == 8'h01 |=> x_ea_o < 16'h2000)
    else $error("file address beyond near region");
  a_file_dest: assert property (req_i && file_reg_i |=> dest_reg_o == 4'h0)
    else $error("file destination not register zero");
  a_ind_plain: assert property (req_i && x_mode_i == 8'h04 |=> x_ea_o == $past(x_base_i) && !x_wb_en_o)
    else $error("plain indirect address wrong");
  a_post_keep: assert property (req_i && x_mode_i == 8'h08 |=> x_ea_o == $past(x_base_i) && x_wb_en_o)
    else $error("post modify address wrong");
  a_pre_first: assert property (req_i && x_mode_i == 8'h10 |=> x_ea_o == x_wb_val_o && x_wb_en_o)
    else $error("pre modify address wrong");
  a_src1_reg: assert property (req_i && three_op_i |=> src1_reg_o == $past(x_offset_i))
    else $error("first source not register direct");
  a_wb_only: assert property (x_wb_en_o |-> $past(req_i) && $past(x_mode_i) inside {8'h08, 8'h10})
    else $error("write-back outside pre or post");
  a_offset_nowb: assert property (req_i && x_mode_i inside {8'h20, 8'h40} |=> !x_wb_en_o)
    else $error("offset form wrote back");
  c_post: cover property (req_i && x_mode_i == 8'h08);
  c_mac: cover property (y_valid_o);
  c_file: cover property (req_i && file_reg_i && x_mode_i == 8'h01);
endmodule : dag_monitor
bind dag_top dag_monitor u_mon (.clk_i, .resetn_i, .req_i, .mac_word_read_i, .file_reg_i, .move_i,
  .three_op_i, .x_mode_i, .x_base_i, .x_offset_i, .x_program_space_i, .x_ea_o, .x_wb_val_o, .x_wb_en_o,
  .x_program_space_o, .y_ea_o, .y_valid_o, .dest_reg_o, .src1_reg_o, .ea_valid_o);
`default_nettype wire

// ==== tb/dag_regfile_model.sv ====
// Purpose: working register file on the decoder side
// Assumes: write-back one edge after request
// Notes: load port stands for a plain register move
`timescale 1ns/1ps
`default_nettype none
module dag_regfile_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] x_sel_i,
  input wire logic [3:0] y_sel_i,
  input wire logic x_wb_en_i,
  input wire logic y_wb_en_i,
  input wire logic [15:0] x_wb_val_i,
  input wire logic [15:0] y_wb_val_i,
  input wire logic load_en_i,
  input wire logic [3:0] load_sel_i,
  input wire logic [15:0] load_val_i,
  output logic [15:0] x_ptr_o,
  output logic [15:0] y_ptr_o
);
  logic [15:0] regs [16];
  logic [3:0] x_sel_q;
  logic [3:0] y_sel_q;
  assign x_ptr_o = regs[x_sel_i];
  assign y_ptr_o = regs[y_sel_i];
  always_ff @(posedge clk_i) begin
    x_sel_q <= x_sel_i;
    y_sel_q <= y_sel_i;
    if (!resetn_i) begin
      for (int i = 0; i < 16; i++) regs[i] <= 16'h0;
    end else begin
      if (x_wb_en_i) regs[x_sel_q] <= x_wb_val_i;
      if (y_wb_en_i) regs[y_sel_q] <= y_wb_val_i;
      if (load_en_i) regs[load_sel_i] <= load_val_i;
    end
  end
endmodule : dag_regfile_model
`default_nettype wire

// ==== tb/data_address_generator_test.sv ====
// Purpose: self-checking bench for dag_top
// Assumes: 200 MHz clock, sync active-low reset
// Notes: expectations queued by drivers, checked at negedge
`timescale 1ns/1ps
`default_nettype none
module data_address_generator_test;
  typedef struct packed {logic [15:0] xea; logic [15:0] xwb; logic wben; logic [15:0] yea; logic yv;} dag_exp_s;
  logic clk_i = 1'b0, resetn_i = 1'b0, req_i = 1'b0, mac_word_read_i = 1'b0, file_reg_i = 1'b0;
  logic move_i = 1'b0, three_op_i = 1'b0, lit10_i = 1'b0, x_program_space_i = 1'b0, load_en = 1'b0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [6:0] avs_address_i = 7'h0;
  logic [1:0] avs_byteenable_i = 2'h3, src2_kind_i = 2'h0;
  logic [9:0] short_literal_i = 10'h0;
  logic [7:0] x_mode_i = 8'h04, y_mode_i = 8'h08;
  logic [3:0] x_base_sel_i = 4'h0, y_base_sel_i = 4'ha, load_sel = 4'h0, dest_reg_o;
  logic [15:0] avs_writedata_i = 16'h0, x_offset_i = 16'h0, x_literal_i = 16'h0, x_step_i = 16'h0;
  logic [15:0] y_offset_i = 16'h0, y_step_i = 16'h0002, load_val = 16'h0;
  wire [15:0] x_base_i, y_base_i;
  logic [15:0] avs_readdata_o, x_ea_o, x_wb_val_o, y_ea_o, y_wb_val_o, src1_reg_o, src2_literal_o, core_control_o;
  logic avs_waitrequest_o, x_wb_en_o, x_program_space_o, y_wb_en_o, y_valid_o, src2_is_memory_o, ea_valid_o;
  logic [13:0] disi_count_o;
  logic [15:0] rd_q [$];
  logic [16:0] s2_q [$], s2;
  dag_exp_s exp_q [$];
  dag_exp_s ew;
  int bad_count = 0, cmp_count = 0;
  logic [15:0] rv [9] = '{16'h0020, 16'h0, 16'h0, 16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0};
  logic [7:0] m;
  logic [15:0] b, o, st, yb, ea;
  logic mac;
  always #2.5 clk_i = ~clk_i;
  dag_top DUT (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .req_i, .mac_word_read_i, .file_reg_i, .move_i,
    .three_op_i, .src2_kind_i, .short_literal_i, .lit10_i, .x_mode_i, .x_base_sel_i, .x_base_i, .x_offset_i,
    .x_literal_i, .x_step_i, .x_program_space_i, .y_mode_i, .y_base_sel_i, .y_base_i, .y_offset_i, .y_step_i,
    .x_ea_o, .x_wb_val_o, .x_wb_en_o, .x_program_space_o, .y_ea_o, .y_wb_val_o, .y_wb_en_o, .y_valid_o,
    .dest_reg_o, .src1_reg_o, .src2_literal_o, .src2_is_memory_o, .ea_valid_o, .core_control_o, .disi_count_o);
  dag_regfile_model u_regs (.clk_i, .resetn_i, .x_sel_i(x_base_sel_i), .y_sel_i(y_base_sel_i),
    .x_wb_en_i(x_wb_en_o), .y_wb_en_i(y_wb_en_o), .x_wb_val_i(x_wb_val_o), .y_wb_val_i(y_wb_val_o),
    .load_en_i(load_en), .load_sel_i(load_sel), .load_val_i(load_val), .x_ptr_o(x_base_i), .y_ptr_o(y_base_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      bad_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic bus(input logic wr, input logic [6:0] a, input logic [15:0] d, input logic [15:0] e);
    int n;
    n = 0;
    if (!wr) rd_q.push_back(e);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(negedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 20) begin
        bad_count++;
        give_verdict();
      end
      @(negedge clk_i);
    end
    @(posedge clk_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic load(input logic [3:0] s, input logic [15:0] v);
    load_en <= 1'b1;
    load_sel <= s;
    load_val <= v;
    @(posedge clk_i);
    load_en <= 1'b0;
    @(posedge clk_i);
  endtask : load
  task automatic issue(input logic [7:0] md, input logic [3:0] s, input logic [15:0] bs, input logic [15:0] of,
                       input logic [15:0] sp, input dag_exp_s e);
    load(s, bs);
    exp_q.push_back(e);
    s2_q.push_back({three_op_i && src2_kind_i == 2'h1,
                    lit10_i ? {6'h00, short_literal_i} : {11'h000, short_literal_i[4:0]}});
    req_i <= 1'b1;
    x_mode_i <= md;
    x_base_sel_i <= s;
    x_offset_i <= of;
    x_literal_i <= of;
    x_step_i <= sp;
    @(posedge clk_i);
    req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : issue
  // ----------------------------------------
  // result watchers
  // ----------------------------------------
  always @(negedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) check(avs_readdata_o, rd_q.size() ? rd_q.pop_front() : 'x);
    if (ea_valid_o === 1'b1) begin
      ew = exp_q.size() ? exp_q.pop_front() : 'x;
      check(x_ea_o, ew.xea);
      check({15'h0, x_wb_en_o}, {15'h0, ew.wben});
      if (ew.wben) check(x_wb_val_o, ew.xwb);
      check(y_ea_o, ew.yea);
      check({15'h0, y_valid_o}, {15'h0, ew.yv});
      check({15'h0, y_wb_en_o}, {15'h0, ew.yv});
      check(y_wb_val_o, ew.yv ? 16'(ew.yea + 16'h0002) : 16'h0000);
      s2 = s2_q.size() ? s2_q.pop_front() : 'x;
      check(src2_literal_o, s2[15:0]);
      check({15'h0, src2_is_memory_o}, {15'h0, s2[16]});
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(61186));
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 9; i++) bus(1'b0, (i < 8) ? 7'(7'h44 + 2 * i) : 7'h40, 16'h0, rv[i]);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 7'(7'h48 + 2 * i), i[0] ? 16'h0000 : 16'hffff, 16'h0);
      bus(1'b0, 7'(7'h48 + 2 * i), 16'h0, i[0] ? 16'h0001 : 16'hfffe);
    end
    bus(1'b1, 7'h40, 16'hffff, 16'h0);
    bus(1'b0, 7'h40, 16'h0, 16'h0);
    bus(1'b1, 7'h46, 16'hffff, 16'h0);
    bus(1'b0, 7'h46, 16'h0, 16'hcfff);
    for (int i = 0; i < 25; i++) begin
      m = 8'h04 << (i % 5);
      b = {1'b0, 14'($urandom), 1'b0};
      o = {8'h0, 7'($urandom), 1'b0};
      st = $urandom_range(0, 1) ? 16'h0004 : 16'hfffe;
      yb = {1'b0, 14'($urandom), 1'b0};
      mac = 1'($urandom);
      mac_word_read_i <= mac;
      x_program_space_i <= 1'($urandom);
      three_op_i <= 1'($urandom);
      short_literal_i <= 10'($urandom);
      lit10_i <= 1'($urandom);
      src2_kind_i <= 2'($urandom);
      load(4'ha, yb);
      ea = (m == 8'h10) ? b + st : (m >= 8'h20) ? b + o : b;
      issue(m, 4'(i % 8), b, o, st, '{ea, b + st, m inside {8'h08, 8'h10}, mac ? yb : 16'h0, mac});
    end
    mac_word_read_i <= 1'b0;
    file_reg_i <= 1'b1;
    issue(8'h01, 4'h0, 16'h0, 16'habcd, 16'h0, '{16'h0bcd, 16'h0, 1'b0, 16'h0, 1'b0});
    move_i <= 1'b1;
    issue(8'h01, 4'h0, 16'h0, 16'habcd, 16'h0, '{16'habcd, 16'h0, 1'b0, 16'h0, 1'b0});
    file_reg_i <= 1'b0;
    move_i <= 1'b0;
    bus(1'b1, 7'h48, 16'h1000, 16'h0);
    bus(1'b1, 7'h4a, 16'h100f, 16'h0);
    bus(1'b1, 7'h46, 16'h8ff3, 16'h0);
    issue(8'h08, 4'h3, 16'h100e, 16'h0, 16'h0004, '{16'h100e, 16'h1002, 1'b1, 16'h0, 1'b0});
    issue(8'h20, 4'h3, 16'h1002, 16'h000e, 16'h0, '{16'h1000, 16'h0, 1'b0, 16'h0, 1'b0});
    bus(1'b1, 7'h46, 16'h8fff, 16'h0);
    issue(8'h08, 4'h3, 16'h1002, 16'h0, 16'h0010, '{16'h1002, 16'h1012, 1'b1, 16'h0, 1'b0});
    x_program_space_i <= 1'b0;
    bus(1'b1, 7'h50, 16'h8008, 16'h0);
    bus(1'b1, 7'h46, 16'h03ff, 16'h0);
    issue(8'h08, 4'h3, 16'h1008, 16'h0, 16'h0002, '{16'h1008, 16'h1004, 1'b1, 16'h0, 1'b0});
    check(16'(exp_q.size() + rd_q.size()), 16'h0);
    give_verdict();
  end
endmodule : data_address_generator_test
`default_nettype wire
